// file: parallel_video_input_2d_3d_bench.sv
/*
 * Self-checking bench for the video input port: random small frames in
 * every format, eye flips mid-frame, frame status and glasses sync.
 * Assumes pvi_src as the source and no real-size frames (run length).
 */
`timescale 1ns/1ps
`default_nettype none
module parallel_video_input_2d_3d_bench;
	import pvi_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic clk_sys; // 40 MHz system clock
	logic pix_clk; // 8 MHz pixel clock, own phase
	logic rst;
	pvi_fmt_t cfg_fmt;
	logic cfg_3d;
	pvi_vin_t vin;
	pvi_pix_t pix_out;
	pvi_stat_t stat_out;
	logic glasses_sync;
	int n_errors = 0;
	int cmp_count = 0;
	int n_ds = 0; // Display starts seen
	int w, h;
	logic eye, odd_n;
	logic [7:0] cb; // Blue chroma of the current pair
	logic [25:0] r;
	logic [23:0] e;
	logic [22:0] f;
	logic [22:0] frm_q[$]; // Expected width, lines, eye per frame
	// ****************************************
	// Clocks and instances
	// ****************************************
	always #12.5 clk_sys = ~clk_sys;
	initial begin
		pix_clk = 0;
		#7.3;
		forever #62.5 pix_clk = ~pix_clk;
	end
	pvi_port i_dut (.clk_sys(clk_sys), .rst(rst), .cfg_fmt(cfg_fmt),
		.cfg_3d(cfg_3d), .pix_clk(pix_clk), .vin(vin), .pix_out(pix_out),
		.stat_out(stat_out), .glasses_sync(glasses_sync));
	pvi_src i_src (.pix_clk(pix_clk), .vin(vin));
	// ****************************************
	// Expectations and compares
	// ****************************************
	// Narrow fields widen by repeating their top bits
	function automatic logic [23:0] unpack(input pvi_fmt_t m, input logic [23:0] d);
		case (m)
			PVI_FMT_666: return {d[17:12], d[17:16], d[11:6], d[11:10], d[5:0], d[5:4]};
			PVI_FMT_565: return {d[15:11], d[15:13], d[10:5], d[10:9], d[4:0], d[4:2]};
			default: return d;
		endcase
	endfunction
	task automatic chk_pix(input string what, input logic [23:0] x, g);
		cmp_count++;
		if (g !== x) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, x, g);
		end
	endtask
	task automatic chk_frm(input string what, input logic [22:0] x, g);
		cmp_count++;
		if (g !== x) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, x, g);
		end
	endtask
	task automatic complete_run;
		$display("Compares %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Pixel monitor; 4:2:2 pairs are even width per line, so parity holds
	always @(negedge pix_clk) begin
		if (!rst && pix_out.valid === 1'b1 && i_src.raw_q.size() > 0) begin
			r = i_src.raw_q.pop_front();
			if (r[25]) odd_n = 1'b0;
			if (cfg_fmt == PVI_FMT_422) begin
				if (!odd_n) begin
					cb = r[7:0];
					e = {r[15:8], r[7:0], i_src.raw_q[0][7:0]};
				end else begin
					e = {r[15:8], cb, r[7:0]};
				end
				odd_n = ~odd_n;
			end else begin
				e = unpack(cfg_fmt, r[23:0]);
			end
			chk_pix("pixel", e, {pix_out.c0, pix_out.c1, pix_out.c2});
			chk_pix("sof_eye", {22'h0, r[25:24]}, {22'h0, pix_out.sof, pix_out.eye});
		end else if (!rst && pix_out.valid === 1'b1) begin
			// A pixel out of nothing is a fault, not something to skip
			n_errors++;
			$display("BAD pixel expected none seen %h", pix_out.c0);
		end
	end
	// Frame monitor; the first start after reset has no finished frame
	always @(negedge clk_sys) begin
		if (!rst && stat_out.disp_start === 1'b1) begin
			n_ds++;
			if (n_ds > 1 && frm_q.size() > 0) begin
				f = frm_q.pop_front();
				chk_frm("size_eye", f, {stat_out.w, stat_out.h, stat_out.eye_shown});
				chk_frm("glasses", {22'h0, f[0]}, {22'h0, glasses_sync});
				chk_frm("ok_up", 23'h1, {21'h0, stat_out.frame_ok, stat_out.upscale});
			end
		end
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		clk_sys = 0;
		rst = 1;
		cfg_fmt = PVI_FMT_888;
		cfg_3d = 0;
		odd_n = 0;
		void'($urandom(48));
		// Long enough for the pixel side to see reset too
		repeat (24) @(negedge clk_sys);
		rst = 0;
		repeat (8) @(negedge clk_sys);
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 3; k++) begin
				@(negedge clk_sys);
				cfg_fmt = pvi_fmt_t'(m);
				cfg_3d = 1'($urandom);
				w = 2 * (1 + $urandom % 4);
				h = 1 + $urandom % 3;
				eye = 1'($urandom);
				frm_q.push_back({11'(w), 11'(h), eye});
				i_src.send_frame(w, h, eye, k == 1);
			end
		end
		// Trailing frame closes the last checked one
		i_src.send_frame(2, 1, 1'b0, 1'b0);
		for (int t = 0; t < 400 && frm_q.size() > 0; t++) @(negedge clk_sys);
		if (frm_q.size() > 0) n_errors++;
		// Every sent pixel must have come out again
		if (i_src.raw_q.size() > 0) n_errors++;
		complete_run;
	end
	// Hang guard
	initial begin
		#1_000_000;
		n_errors++;
		complete_run;
	end
endmodule
`default_nettype wire

// file: pvi_pkg.sv
/*
 * Shared constants and carrier types of the parallel video input port.
 * Assumes a 40 MHz system clock and a source-driven pixel clock.
 */
`default_nettype none
package pvi_pkg;
	// ****************************************
	// Timing and rate windows
	// ****************************************
	localparam int unsigned CLK_SYS_HZ = 40_000_000; // System clock rate
	localparam int unsigned RATE_2D_MIN_HZ = 10; // 2D window low end
	localparam int unsigned RATE_2D_MAX_HZ = 62; // 2D window high end
	localparam int unsigned RATE_3DA_MIN_HZ = 98; // 3D 100 Hz band
	localparam int unsigned RATE_3DA_MAX_HZ = 102;
	localparam int unsigned RATE_3DB_MIN_HZ = 118; // 3D 120 Hz band
	localparam int unsigned RATE_3DB_MAX_HZ = 122;
	localparam int unsigned PCLK_MAX_HZ = 150_000_000; // Pixel clock ceiling
	localparam int unsigned PER_W = 23; // Frame period counter width
	// ****************************************
	// Frame geometries
	// ****************************************
	localparam logic [10:0] W_FULL = 11'h780; // 1920
	localparam logic [10:0] H_FULL = 11'h438; // 1080
	localparam logic [10:0] W_HD = 11'h500; // 1280
	localparam logic [10:0] H_HD = 11'h2d0; // 720
	localparam logic [10:0] W_HALF = 11'h3c0; // 960
	localparam logic [10:0] H_HALF = 11'h21c; // 540
	// ****************************************
	// Formats and carriers
	// ****************************************
	typedef enum logic [1:0] {
		PVI_FMT_888 = 2'h0,
		PVI_FMT_666 = 2'h1,
		PVI_FMT_565 = 2'h2,
		PVI_FMT_422 = 2'h3
	} pvi_fmt_t;
	localparam pvi_fmt_t FMT_RST = PVI_FMT_888; // Format after reset
	// Raw pins of the port
	typedef struct packed {
		logic vs; // Frame sync
		logic hs; // Line sync
		logic de; // active_data_valid
		logic eye; // eye_select_input, high = right
		logic [23:0] d; // pixel_data_bus
	} pvi_vin_t;
	// Unpacked pixel toward the display path
	typedef struct packed {
		logic valid;
		logic sof; // First pixel of a frame
		logic eye; // Eye tag of the frame
		logic [7:0] c0; // R or Y
		logic [7:0] c1; // G or Cb
		logic [7:0] c2; // B or Cr
	} pvi_pix_t;
	// Per-frame status in the system domain
	typedef struct packed {
		logic frame_ok; // Size and rate accepted
		logic upscale; // Frame needs enlarging to full size
		logic eye_shown; // Eye now displayed
		logic disp_start; // One-cycle display frame start
		logic [10:0] w; // Measured active width
		logic [10:0] h; // Measured active lines
	} pvi_stat_t;
endpackage
`default_nettype wire

// file: pvi_port.sv
/*
 * Parallel video input port: pin capture, format unpack, eye tagging,
 * frame measurement and glasses sync.
 * Assumes the source meets the sync spacing and shows 3D frame-sequential.
 */
// Functional notes
// - 2D accept 1920x1080 at 10-62 Hz
// - 2D accept 1280x720 at 10-62 Hz, enlarge
// - 3D accept three reduced sizes at 100/120 Hz
// - Pixel clock max 150 MHz, no full 120 Hz
// - Eye select input tags each frame
// - One displayed frame per input frame
// - Glasses sync in phase with shown eye
// - 888, 666, 565 packings selectable
// - 4:2:2 Cb on even, Cr on odd
`timescale 1ns/1ps
`default_nettype none
module pvi_port
	import pvi_pkg::*;
#(
	parameter logic [PER_W-1:0] P2D_MIN = PER_W'(CLK_SYS_HZ / RATE_2D_MAX_HZ),
	parameter logic [PER_W-1:0] P2D_MAX = PER_W'(CLK_SYS_HZ / RATE_2D_MIN_HZ),
	parameter logic [PER_W-1:0] P3A_MIN = PER_W'(CLK_SYS_HZ / RATE_3DA_MAX_HZ),
	parameter logic [PER_W-1:0] P3A_MAX = PER_W'(CLK_SYS_HZ / RATE_3DA_MIN_HZ),
	parameter logic [PER_W-1:0] P3B_MIN = PER_W'(CLK_SYS_HZ / RATE_3DB_MAX_HZ),
	parameter logic [PER_W-1:0] P3B_MAX = PER_W'(CLK_SYS_HZ / RATE_3DB_MIN_HZ)
) (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Configuration, system domain
	input wire pvi_pkg::pvi_fmt_t cfg_fmt,
	input wire logic cfg_3d,
	// Pixel link, source clocked
	input wire logic pix_clk,
	input wire pvi_pkg::pvi_vin_t vin,
	// Pixel stream, pix_clk domain
	output pvi_pkg::pvi_pix_t pix_out,
	// Frame status and glasses, system domain
	output pvi_pkg::pvi_stat_t stat_out,
	output logic glasses_sync
);
	import pvi_pkg::*;

	// ****************************************
	// Pixel domain reset
	// ****************************************
	logic rp1_r; // First stage, read only by rp2_r
	logic rp2_r; // Reset in pix_clk domain
	// Reset is held for many pixel clocks, so a plain level sync suffices
	always_ff @(posedge pix_clk) begin
		rp1_r <= rst;
		rp2_r <= rp1_r;
	end

	// ****************************************
	// Pixel domain state
	// ****************************************
	typedef struct packed {
		logic [1:0] fmt1; // Format sync, first stage
		pvi_fmt_t fmt2; // Format in use
		pvi_vin_t in; // Captured pins
		logic vs_d; // Frame sync delayed
		logic de_d; // Valid delayed
		logic eye_tag; // Eye of current frame
		logic sof_pend; // Next pixel starts a frame
		logic phase; // 4:2:2 odd pixel next
		logic pend; // Odd 4:2:2 pixel waiting
		logic [7:0] py; // Held luma
		logic [7:0] cb; // Held blue chroma
		logic [7:0] cr; // Held red chroma
		logic [10:0] wcnt; // Pixels in this line
		logic [10:0] wlast; // Pixels of last line
		logic [10:0] hcnt; // Lines in this frame
		logic [10:0] fw; // Width of finished frame
		logic [10:0] fh; // Height of finished frame
		logic feye; // Eye of finished frame
		logic tgl; // Frame event toggle
		pvi_pix_t out; // Output pixel
	} pvi_pst_t;
	pvi_pst_t p_r;
	pvi_pst_t p_nxt;
	logic fs_rise; // Frame sync leading edge
	logic de_rise; // Line start

	// Capture, unpack and measure per pixel clock
	always_comb begin
		p_nxt = p_r;
		p_nxt.fmt1 = cfg_fmt;
		p_nxt.fmt2 = pvi_fmt_t'(p_r.fmt1);
		p_nxt.in = vin;
		p_nxt.vs_d = p_r.in.vs;
		p_nxt.de_d = p_r.in.de;
		p_nxt.out.valid = 1'b0;
		p_nxt.out.eye = p_r.eye_tag;
		fs_rise = p_r.in.vs & ~p_r.vs_d;
		de_rise = p_r.in.de & ~p_r.de_d;
		// Frame boundary: hand the finished frame over
		if (fs_rise) begin
			p_nxt.fw = p_r.wlast;
			p_nxt.fh = p_r.hcnt;
			p_nxt.feye = p_r.eye_tag;
			p_nxt.tgl = ~p_r.tgl;
			p_nxt.hcnt = 11'h000;
			p_nxt.eye_tag = p_r.in.eye;
			p_nxt.sof_pend = 1'b1;
		end else if (de_rise) begin
			p_nxt.hcnt = p_r.hcnt + 11'h001;
		end
		// Line width count
		if (de_rise) begin
			p_nxt.wcnt = 11'h001;
			p_nxt.phase = 1'b0;
		end else if (p_r.in.de) begin
			p_nxt.wcnt = p_r.wcnt + 11'h001;
		end else if (p_r.de_d) begin
			p_nxt.wlast = p_r.wcnt;
		end
		// Format unpack, narrow fields widened by top-bit replication
		unique case (p_r.fmt2)
			PVI_FMT_888: begin
				p_nxt.out.valid = p_r.in.de;
				p_nxt.out.c0 = p_r.in.d[23:16];
				p_nxt.out.c1 = p_r.in.d[15:8];
				p_nxt.out.c2 = p_r.in.d[7:0];
			end
			PVI_FMT_666: begin
				p_nxt.out.valid = p_r.in.de;
				p_nxt.out.c0 = {p_r.in.d[17:12], p_r.in.d[17:16]};
				p_nxt.out.c1 = {p_r.in.d[11:6], p_r.in.d[11:10]};
				p_nxt.out.c2 = {p_r.in.d[5:0], p_r.in.d[5:4]};
			end
			PVI_FMT_565: begin
				p_nxt.out.valid = p_r.in.de;
				p_nxt.out.c0 = {p_r.in.d[15:11], p_r.in.d[15:13]};
				p_nxt.out.c1 = {p_r.in.d[10:5], p_r.in.d[10:9]};
				p_nxt.out.c2 = {p_r.in.d[4:0], p_r.in.d[4:2]};
			end
			PVI_FMT_422: begin
				// Even pixel lacks Cr until its odd partner arrives, so the
				// pair leaves one pixel late; a lone even pixel is dropped
				if (p_r.in.de && !(p_r.phase && !de_rise)) begin
					if (p_r.pend) begin
						p_nxt.out.valid = 1'b1;
						p_nxt.out.c0 = p_r.py;
						p_nxt.out.c1 = p_r.cb;
						p_nxt.out.c2 = p_r.cr;
					end
					p_nxt.py = p_r.in.d[15:8];
					p_nxt.cb = p_r.in.d[7:0];
					p_nxt.phase = 1'b1;
					p_nxt.pend = 1'b0;
				end else if (p_r.in.de) begin
					p_nxt.out.valid = 1'b1;
					p_nxt.out.c0 = p_r.py;
					p_nxt.out.c1 = p_r.cb;
					p_nxt.out.c2 = p_r.in.d[7:0];
					p_nxt.py = p_r.in.d[15:8];
					p_nxt.cr = p_r.in.d[7:0];
					p_nxt.phase = 1'b0;
					p_nxt.pend = 1'b1;
				end else if (p_r.pend) begin
					p_nxt.out.valid = 1'b1;
					p_nxt.out.c0 = p_r.py;
					p_nxt.out.c1 = p_r.cb;
					p_nxt.out.c2 = p_r.cr;
					p_nxt.pend = 1'b0;
				end
			end
		endcase
		// Mark the first pixel of each frame
		p_nxt.out.sof = p_nxt.out.valid & p_nxt.sof_pend;
		if (p_nxt.out.valid) begin
			p_nxt.sof_pend = 1'b0;
		end
	end

	// Pixel domain register
	always_ff @(posedge pix_clk) begin
		if (rp2_r) begin
			p_r <= '0;
			p_r.fmt2 <= FMT_RST;
		end else begin
			p_r <= p_nxt;
		end
	end
	assign pix_out = p_r.out;

	// ****************************************
	// System domain state
	// ****************************************
	typedef struct packed {
		logic t1; // Toggle sync, first stage
		logic t2;
		logic t3; // Previous synced toggle
		logic seen; // A previous frame start exists
		logic [PER_W-1:0] per; // Cycles since last frame
		pvi_stat_t stat;
	} pvi_sst_t;
	pvi_sst_t s_r;
	pvi_sst_t s_nxt;
	logic ev; // Frame event in system domain
	logic sz2d; // Size fits 2D list
	logic sz3d; // Size fits 3D list
	logic rt2d; // Period in 2D window
	logic rt3d; // Period in either 3D band

	// Judge each finished frame and pace the display
	always_comb begin
		s_nxt = s_r;
		s_nxt.t1 = p_r.tgl;
		s_nxt.t2 = s_r.t1;
		s_nxt.t3 = s_r.t2;
		s_nxt.stat.disp_start = 1'b0;
		ev = s_r.t2 ^ s_r.t3;
		sz2d = (p_r.fw == W_FULL && p_r.fh == H_FULL) ||
			(p_r.fw == W_HD && p_r.fh == H_HD);
		// Full size is absent here: at 120 Hz it outruns the pixel clock
		sz3d = (p_r.fw == W_FULL && p_r.fh == H_HALF) ||
			(p_r.fw == W_HALF && p_r.fh == H_FULL) ||
			(p_r.fw == W_HD && p_r.fh == H_HD);
		rt2d = s_r.per >= P2D_MIN && s_r.per <= P2D_MAX;
		rt3d = (s_r.per >= P3A_MIN && s_r.per <= P3A_MAX) ||
			(s_r.per >= P3B_MIN && s_r.per <= P3B_MAX);
		if (s_r.per != {PER_W{1'b1}}) begin
			s_nxt.per = s_r.per + PER_W'(1);
		end
		// Fields of the finished frame are held a whole frame, so stable here
		if (ev) begin
			s_nxt.per = PER_W'(1);
			s_nxt.seen = 1'b1;
			s_nxt.stat.w = p_r.fw;
			s_nxt.stat.h = p_r.fh;
			s_nxt.stat.disp_start = 1'b1;
			s_nxt.stat.eye_shown = p_r.feye;
			s_nxt.stat.frame_ok = s_r.seen &&
				(cfg_3d ? (sz3d && rt3d) : (sz2d && rt2d));
			s_nxt.stat.upscale = !(p_r.fw == W_FULL && p_r.fh == H_FULL);
		end
	end

	// System domain register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign stat_out = s_r.stat;
	assign glasses_sync = s_r.stat.eye_shown;

	// ****************************************
	// Checks
	// ****************************************
	a_eye_frame_hold: assert property (@(posedge pix_clk) disable iff (rp2_r)
		!$past(fs_rise) |-> $stable(p_r.eye_tag))
		else $error("eye tag changed inside a frame");
	a_eye_pin_tag: assert property (@(posedge pix_clk) disable iff (rp2_r)
		fs_rise |=> p_r.eye_tag == $past(p_r.in.eye))
		else $error("eye tag not taken from pin at frame start");
	a_fmt_565_map: assert property (@(posedge pix_clk) disable iff (rp2_r)
		p_r.in.de && p_r.fmt2 == PVI_FMT_565 |=> p_r.out.valid &&
		p_r.out.c0 == {$past(p_r.in.d[15:11]), $past(p_r.in.d[15:13])})
		else $error("565 red field mismapped");
	a_chroma_odd: assert property (@(posedge pix_clk) disable iff (rp2_r)
		p_r.in.de && p_r.phase && !de_rise && p_r.fmt2 == PVI_FMT_422
		|=> p_r.out.valid && p_r.out.c2 == $past(p_r.in.d[7:0]) &&
		p_r.out.c1 == $past(p_r.cb))
		else $error("4:2:2 red chroma not on odd pixel");
	a_disp_per_frame: assert property (@(posedge clk_sys) disable iff (rst)
		ev |=> s_r.stat.disp_start ##1 !s_r.stat.disp_start)
		else $error("display start not one per input frame");
	a_glasses_phase: assert property (@(posedge clk_sys) disable iff (rst)
		$changed(glasses_sync) |-> $past(ev))
		else $error("glasses sync moved off a display frame start");
	a_accept_2d_full: assert property (@(posedge clk_sys) disable iff (rst)
		ev && s_r.seen && !cfg_3d && p_r.fw == W_FULL && p_r.fh == H_FULL &&
		s_r.per >= P2D_MIN && s_r.per <= P2D_MAX |=> s_r.stat.frame_ok)
		else $error("full 2D frame refused");
	a_accept_2d_hd: assert property (@(posedge clk_sys) disable iff (rst)
		ev && s_r.seen && !cfg_3d && p_r.fw == W_HD && p_r.fh == H_HD &&
		rt2d |=> s_r.stat.frame_ok && s_r.stat.upscale)
		else $error("720 line 2D frame refused or not enlarged");
	a_accept_3d: assert property (@(posedge clk_sys) disable iff (rst)
		ev && s_r.seen && cfg_3d && p_r.fw == W_HALF && p_r.fh == H_FULL &&
		s_r.per >= P3B_MIN && s_r.per <= P3B_MAX
		|=> s_r.stat.frame_ok && s_r.stat.upscale)
		else $error("half width 3D frame refused");
	a_no_full_3d: assert property (@(posedge clk_sys) disable iff (rst)
		ev && cfg_3d && p_r.fw == W_FULL && p_r.fh == H_FULL
		|=> !s_r.stat.frame_ok)
		else $error("full size 3D frame accepted");
endmodule
`default_nettype wire

// file: pvi_src.sv
/*
 * Behavioural video source that drives the pixel pins frame by frame.
 * Assumes the bench supplies a free-running pix_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pvi_src
	import pvi_pkg::*;
(
	// Pixel clock from the bench
	input wire logic pix_clk,
	// Pins toward the port
	output pvi_pkg::pvi_vin_t vin
);
	import pvi_pkg::*;
	// ****************************************
	// Pin driving
	// ****************************************
	logic [25:0] raw_q[$]; // Sent pixels: sof, frame eye, data
	// One pixel clock of pins; idle data is the inverse of the last value,
	// so a port that samples outside valid data sees garbage
	task automatic tick(input logic vs, hs, de, eye, input logic [23:0] d);
		@(negedge pix_clk);
		vin = '{vs, hs, de, eye, de ? d : ~vin.d};
	endtask
	// One line: sync 4 clocks, data, front porch 8 clocks
	task automatic line(input logic vs, eye, fe, input int w, input bit sof);
		logic [23:0] d;
		for (int i = 0; i < 4; i++) tick(vs, 1'b1, 1'b0, eye, 24'h0);
		for (int i = 0; i < w; i++) begin
			d = 24'($urandom);
			tick(vs, 1'b0, 1'b1, eye, d);
			raw_q.push_back({sof && i == 0, fe, d});
		end
		for (int i = 0; i < 8; i++) tick(vs, 1'b0, 1'b0, eye, 24'h0);
	endtask
	// Frame: sync line, blank line, active lines, blank line
	// A flip scenario turns the eye pin round after the first active line
	task automatic send_frame(input int w, h, input logic eye, flip);
		line(1'b1, eye, eye, 0, 0);
		line(1'b0, eye, eye, 0, 0);
		for (int l = 0; l < h; l++)
			line(1'b0, (flip && l > 0) ? ~eye : eye, eye, w, l == 0);
		line(1'b0, eye, eye, 0, 0);
	endtask
	initial vin = '0;
endmodule
`default_nettype wire
